// ===== som_lamp_model.sv
// Indicator lamp model watching one status output line.
// Assumes the line is driven synchronously to clock.
`timescale 1ns/1ps
module som_lamp_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic lamp,
    input wire logic count_en,
    output logic [7:0] toggles
);
    // ****************************************
    // Edge counter
    // ****************************************
    logic lamp_reg;
    // Count stays cleared while idle, so each window starts from zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lamp_reg <= 1'b0;
            toggles <= 8'h00;
        end else begin
            lamp_reg <= lamp;
            if (!count_en) begin
                toggles <= 8'h00;
            end else if (lamp !== lamp_reg) begin
                toggles <= toggles + 8'h01;
            end
        end
    end
endmodule

// ===== som_mapper.sv
// Status output function mapper: physical and virtual status outputs.
// Assumes all inputs are synchronous, debounced and tested upstream.
// Notes on behaviour
// - Each output has a polarity bit; convention one drives high when active.
// - Convention two inverts the output for every function.
// - Reset configuration selects convention one.
// - Track input follows the debounced input run state.
// - Track output follows physical safety output state by default.
// - Logical option follows commanded state, off at once during off-delay.
// - System lockout active on controller lockout, inactive in run mode.
// - I/O fault active on any single input or output lockout.
// - System wait reset on listed faults or manual power-up reset.
// - Config exit, enable exit, group re-arm never raise wait reset.
// - Output wait reset while a safety output awaits manual reset.
// - Mute on when muted or bypassed, flashing on override, else off.
// - Group tracking marks only the input that turned off first.
// - Group re-arms only by system reset after all inputs are on.
// - Bypass shown only while bypassed, after input seen inactive once.
// - No bypass at power-up until the input has been open.
// - Input fault follows any fault on the selected input.
// - Cancel ok follows the cancel off-delay permission.
// - Up to 32 virtual outputs carry the same functions.
// - Virtual table refreshed well within 100 ms.
// - Only debounced, tested states are used.
`timescale 1ns/1ps
module som_mapper #(
    parameter int NUM_PHYS = som_pkg::SOM_NUM_PHYS,
    parameter int NUM_VIRT = som_pkg::SOM_NUM_VIRT,
    parameter int FLASH_CYCLES = som_pkg::SOM_FLASH_CYCLES,
    parameter int VIRT_CYCLES = som_pkg::SOM_VIRT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_run,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_fault,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_bypass_req,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_muted,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_override,
    input wire logic [som_pkg::SOM_NUM_IN-1:0] in_group,
    input wire logic [som_pkg::SOM_NUM_SO-1:0] so_phys,
    input wire logic [som_pkg::SOM_NUM_SO-1:0] so_cmd,
    input wire logic [som_pkg::SOM_NUM_SO-1:0] so_io_fault,
    input wire logic [som_pkg::SOM_NUM_SO-1:0] so_wait_reset,
    input wire logic [som_pkg::SOM_NUM_SO-1:0] so_cancel_ok,
    input wire som_pkg::som_sys_type sys,
    output logic [som_pkg::SOM_NUM_PHYS-1:0] status_out,
    output logic [som_pkg::SOM_NUM_VIRT-1:0] virt_out
);
    import som_pkg::*;

    // ****************************************
    // Configuration store
    // ****************************************
    som_cfg_type phys_cfg_reg [NUM_PHYS];
    som_cfg_type virt_cfg_reg [NUM_VIRT];
    som_cfg_type phys_cfg_next [NUM_PHYS];
    som_cfg_type virt_cfg_next [NUM_VIRT];
    logic run_reg, run_next;
    som_cfg_type wcfg;

    always_comb begin
        wcfg.func = som_func_type'(wdata[SOM_CFG_FN_LSB +: 4]);
        wcfg.src = wdata[SOM_CFG_SRC_LSB +: SOM_SRC_W];
        wcfg.polarity = wdata[SOM_CFG_POL_BIT];
        wcfg.track_logical = wdata[SOM_CFG_LOG_BIT];
        run_next = run_reg;
        if (wr && addr == SOM_ADDR_CTRL) begin
            run_next = wdata[SOM_CTRL_RUN_BIT];
        end
        for (int i = 0; i < NUM_PHYS; i++) begin
            phys_cfg_next[i] = phys_cfg_reg[i];
            // Settings frozen while running
            if (wr && !run_reg &&
                addr == SOM_ADDR_PHYS_CFG + 8'(i * 4)) begin
                phys_cfg_next[i] = wcfg;
            end
        end
        for (int i = 0; i < NUM_VIRT; i++) begin
            virt_cfg_next[i] = virt_cfg_reg[i];
            if (wr && !run_reg &&
                addr == SOM_ADDR_VIRT_CFG + 8'(i * 4)) begin
                virt_cfg_next[i] = wcfg;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_reg <= 1'b0;
            for (int i = 0; i < NUM_PHYS; i++) begin
                phys_cfg_reg[i] <= som_cfg_type'(SOM_CFG_RESET);
            end
            for (int i = 0; i < NUM_VIRT; i++) begin
                virt_cfg_reg[i] <= som_cfg_type'(SOM_CFG_RESET);
            end
        end else begin
            run_reg <= run_next;
            phys_cfg_reg <= phys_cfg_next;
            virt_cfg_reg <= virt_cfg_next;
        end
    end

    // ****************************************
    // Flash divider
    // ****************************************
    logic [31:0] flash_cnt_reg, flash_cnt_next;
    logic flash_reg, flash_next;

    always_comb begin
        flash_cnt_next = flash_cnt_reg + 32'h1;
        flash_next = flash_reg;
        if (flash_cnt_reg >= 32'(FLASH_CYCLES - 1)) begin
            flash_cnt_next = 32'h0;
            flash_next = !flash_reg; // Equal on and off halves
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flash_cnt_reg <= 32'h0;
            flash_reg <= 1'b0;
        end else begin
            flash_cnt_reg <= flash_cnt_next;
            flash_reg <= flash_next;
        end
    end

    // ****************************************
    // Bypass qualify and group first-off
    // ****************************************
    logic [SOM_NUM_IN-1:0] seen_off_reg, seen_off_next;
    logic [SOM_NUM_IN-1:0] first_off_reg, first_off_next;
    logic group_armed_reg, group_armed_next;
    logic [SOM_NUM_IN-1:0] bypassed;
    logic [SOM_NUM_IN-1:0] grp_off;

    always_comb begin
        // Cleared at reset so power-up bypass is refused
        seen_off_next = seen_off_reg | ~in_run;
        bypassed = in_bypass_req & seen_off_reg;
        grp_off = in_group & ~in_run;
        first_off_next = first_off_reg;
        group_armed_next = group_armed_reg;
        if (group_armed_reg && grp_off != '0) begin
            // Lowest index wins a simultaneous drop
            first_off_next = grp_off & (~grp_off + 16'h1);
            group_armed_next = 1'b0;
        end else if (!group_armed_reg && sys.sys_reset &&
                     grp_off == '0) begin
            first_off_next = '0;
            group_armed_next = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen_off_reg <= '0;
            first_off_reg <= '0;
            group_armed_reg <= 1'b1;
        end else begin
            seen_off_reg <= seen_off_next;
            first_off_reg <= first_off_next;
            group_armed_reg <= group_armed_next;
        end
    end

    // ****************************************
    // Function evaluation
    // ****************************************
    logic sys_wait;

    // Config or enable exit never reach this term
    assign sys_wait = (sys.sys_lockout && sys.all_so_off) ||
        sys.fb_fault || sys.valve_fault || sys.so_fault ||
        sys.lamp_fault || sys.hand_fault || sys.manual_pwrup;

    function automatic logic eval(input som_cfg_type c);
        logic a;
        logic [1:0] so;
        a = 1'b0;
        so = c.src[1:0];
        // All input terms are already debounced and tested
        case (c.func)
            SOM_FN_TRACK_INPUT: a = in_run[c.src];
            SOM_FN_TRACK_OUTPUT: begin
                a = c.track_logical ? so_cmd[so] : so_phys[so];
            end
            SOM_FN_SYS_LOCKOUT: a = sys.sys_lockout && !sys.run_mode;
            SOM_FN_IO_FAULT: a = (|in_fault) || (|so_io_fault);
            SOM_FN_SYS_WAIT_RESET: a = sys_wait;
            SOM_FN_OUT_WAIT_RESET: a = so_wait_reset[so];
            SOM_FN_MUTE: begin
                if (bypassed[c.src] || in_muted[c.src]) begin
                    a = 1'b1;
                end else if (in_override[c.src]) begin
                    a = flash_reg;
                end else begin
                    a = 1'b0;
                end
            end
            SOM_FN_INPUT_GROUP: a = first_off_reg[c.src];
            SOM_FN_BYPASS: a = bypassed[c.src];
            SOM_FN_INPUT_FAULT: a = in_fault[c.src];
            SOM_FN_CANCEL_OK: a = so_cancel_ok[so];
            default: a = 1'b0;
        endcase
        return a ^ c.polarity;
    endfunction

    logic [NUM_PHYS-1:0] phys_next;
    logic [NUM_VIRT-1:0] virt_next;
    logic [NUM_VIRT-1:0] virt_reg;
    logic [31:0] rdata_next;

    always_comb begin
        for (int i = 0; i < NUM_PHYS; i++) begin
            phys_next[i] = eval(phys_cfg_reg[i]);
        end
        // Refreshed every cycle, far inside the network window
        for (int i = 0; i < NUM_VIRT; i++) begin
            virt_next[i] = eval(virt_cfg_reg[i]);
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Stored struct order differs from the register layout
    function automatic logic [31:0] cfg_word(input som_cfg_type c);
        logic [31:0] w;
        w = 32'h0;
        w[SOM_CFG_FN_LSB +: 4] = c.func;
        w[SOM_CFG_SRC_LSB +: SOM_SRC_W] = c.src;
        w[SOM_CFG_POL_BIT] = c.polarity;
        w[SOM_CFG_LOG_BIT] = c.track_logical;
        return w;
    endfunction

    always_comb begin
        rdata_next = 32'h0;
        if (rd) begin
            if (addr == SOM_ADDR_PHYS_OUT) begin
                rdata_next = 32'(status_out);
            end else if (addr == SOM_ADDR_VIRT_OUT) begin
                rdata_next = 32'(virt_reg);
            end else if (addr == SOM_ADDR_CTRL) begin
                rdata_next = 32'(run_reg);
            end else begin
                for (int i = 0; i < NUM_PHYS; i++) begin
                    if (addr == SOM_ADDR_PHYS_CFG + 8'(i * 4)) begin
                        rdata_next = cfg_word(phys_cfg_reg[i]);
                    end
                end
                for (int i = 0; i < NUM_VIRT; i++) begin
                    if (addr == SOM_ADDR_VIRT_CFG + 8'(i * 4)) begin
                        rdata_next = cfg_word(virt_cfg_reg[i]);
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_out <= '0;
            virt_reg <= '0;
            rdata <= 32'h0;
        end else begin
            status_out <= phys_next;
            virt_reg <= virt_next;
            rdata <= rdata_next;
        end
    end

    assign virt_out = virt_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_polarity_invert: assert property (
        phys_cfg_reg[1].polarity && $stable(phys_cfg_reg[1]) &&
        phys_cfg_reg[1].func == SOM_FN_SYS_WAIT_RESET
        |=> status_out[1] == !$past(sys_wait))
        else $error("polarity inversion wrong");
    chk_track_input: assert property (
        phys_cfg_reg[0].func == SOM_FN_TRACK_INPUT &&
        !phys_cfg_reg[0].polarity && $stable(phys_cfg_reg[0])
        |=> status_out[0] == $past(in_run[phys_cfg_reg[0].src]))
        else $error("track input mismatch");
    chk_logical_track: assert property (
        phys_cfg_reg[0].func == SOM_FN_TRACK_OUTPUT &&
        phys_cfg_reg[0].track_logical && !phys_cfg_reg[0].polarity &&
        !so_cmd[phys_cfg_reg[0].src[1:0]] |=> !status_out[0])
        else $error("logical track not off");
    chk_bypass_gate: assert property (
        phys_cfg_reg[0].func == SOM_FN_BYPASS &&
        !phys_cfg_reg[0].polarity &&
        !seen_off_reg[phys_cfg_reg[0].src] |=> !status_out[0])
        else $error("bypass before input seen off");
    chk_group_single: assert property (
        $onehot0(first_off_reg))
        else $error("more than one first-off input");
    chk_group_hold: assert property (
        !group_armed_reg && !sys.sys_reset |=> $stable(first_off_reg))
        else $error("group changed without reset");
    chk_cfg_frozen: assert property (
        run_reg && $past(run_reg) |-> $stable(phys_cfg_reg[0]))
        else $error("config changed in run");
    chk_flash_rate: assert property (
        $changed(flash_reg) |-> flash_cnt_reg == 32'h0)
        else $error("flash toggle off schedule");
    chk_lockout_run: assert property (
        phys_cfg_reg[0].func == SOM_FN_SYS_LOCKOUT &&
        !phys_cfg_reg[0].polarity && $stable(phys_cfg_reg[0]) &&
        sys.run_mode |=> !status_out[0])
        else $error("lockout shown in run");
    // Group behaviour in two steps: latch on a drop, clear on re-arm
    sequence seq_group_drop;
        group_armed_reg && grp_off != '0;
    endsequence
    chk_group_latch: assert property (
        seq_group_drop |=> !group_armed_reg && first_off_reg != '0)
        else $error("group drop not latched");
    sequence seq_group_rearm;
        !group_armed_reg && sys.sys_reset && grp_off == '0;
    endsequence
    chk_group_rearm: assert property (
        seq_group_rearm |=> group_armed_reg && first_off_reg == '0)
        else $error("group not re-armed");
    chk_io_fault: assert property (
        phys_cfg_reg[0].func == SOM_FN_IO_FAULT &&
        !phys_cfg_reg[0].polarity && (in_fault != '0 || so_io_fault != '0)
        |=> status_out[0])
        else $error("io fault not shown");
    chk_sys_wait: assert property (
        phys_cfg_reg[0].func == SOM_FN_SYS_WAIT_RESET &&
        !phys_cfg_reg[0].polarity && (sys.fb_fault || sys.manual_pwrup)
        |=> status_out[0])
        else $error("wait for reset not shown");
    chk_out_wait: assert property (
        phys_cfg_reg[0].func == SOM_FN_OUT_WAIT_RESET &&
        !phys_cfg_reg[0].polarity
        |=> status_out[0] == $past(so_wait_reset[phys_cfg_reg[0].src[1:0]]))
        else $error("output wait mismatch");
    chk_mute_on: assert property (
        phys_cfg_reg[0].func == SOM_FN_MUTE && !phys_cfg_reg[0].polarity &&
        (in_muted[phys_cfg_reg[0].src] || bypassed[phys_cfg_reg[0].src])
        |=> status_out[0])
        else $error("mute not shown");
    chk_input_fault: assert property (
        phys_cfg_reg[0].func == SOM_FN_INPUT_FAULT &&
        !phys_cfg_reg[0].polarity
        |=> status_out[0] == $past(in_fault[phys_cfg_reg[0].src]))
        else $error("input fault mismatch");
    chk_cancel_ok: assert property (
        phys_cfg_reg[0].func == SOM_FN_CANCEL_OK && !phys_cfg_reg[0].polarity
        |=> status_out[0] == $past(so_cancel_ok[phys_cfg_reg[0].src[1:0]]))
        else $error("cancel permission mismatch");
    // Shared settings must give the same level on both tables
    chk_virt_match: assert property (
        virt_cfg_reg[NUM_VIRT-1] == phys_cfg_reg[0]
        |=> virt_reg[NUM_VIRT-1] == status_out[0])
        else $error("virtual output differs");
endmodule

// ===== som_mapper_tb.sv
// Self-checking bench for the status output function mapper.
// Assumes the lamp model file is compiled first.
`timescale 1ns/1ps
`define SOM_CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    fail_count++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module som_mapper_tb;
    import som_pkg::*;
    typedef struct packed {
        logic [9:0] cfg;
        logic [15:0] run;
        logic [15:0] flt;
        logic [3:0] sop;
        logic [3:0] cmd;
        logic [3:0] misc;
        logic [9:0] sysv;
        logic e;
    } som_tb_row_type;
    // ****************************************
    // Signals
    // ****************************************
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] in_run = 16'hffff;
    logic [15:0] in_fault = 16'h0;
    logic [15:0] in_bypass_req = 16'h0;
    logic [15:0] in_muted = 16'h0;
    logic [15:0] in_override = 16'h0;
    logic [15:0] in_group = 16'h0;
    logic [3:0] so_phys = 4'h0;
    logic [3:0] so_cmd = 4'h0;
    logic [3:0] so_io_fault = 4'h0;
    logic [3:0] so_wait_reset = 4'h0;
    logic [3:0] so_cancel_ok = 4'h0;
    som_sys_type sys = '0;
    logic [7:0] status_out;
    logic [31:0] virt_out;
    logic count_en = 1'b0;
    logic [7:0] toggles;
    int fail_count = 0;
    int checks_done = 0;
    som_tb_row_type rows [17] = '{
        '{10'h030, 16'h0008, 16'h0, 4'h0, 4'h0, 4'h0, 10'h000, 1'b1},
        '{10'h030, 16'h0000, 16'h0, 4'h0, 4'h0, 4'h0, 10'h000, 1'b0},
        '{10'h011, 16'hffff, 16'h0, 4'h2, 4'h0, 4'h0, 10'h000, 1'b1},
        '{10'h211, 16'hffff, 16'h0, 4'h2, 4'h0, 4'h0, 10'h000, 1'b0},
        '{10'h002, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h0, 10'h200, 1'b1},
        '{10'h002, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h0, 10'h300, 1'b0},
        '{10'h003, 16'hffff, 16'h0020, 4'h0, 4'h0, 4'h0, 10'h000, 1'b1},
        '{10'h003, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h4, 10'h000, 1'b1},
        '{10'h004, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h0, 10'h040, 1'b1},
        '{10'h004, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h0, 10'h001, 1'b0},
        '{10'h004, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h0, 10'h280, 1'b1},
        '{10'h005, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h1, 10'h000, 1'b1},
        '{10'h036, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h8, 10'h000, 1'b1},
        '{10'h029, 16'hffff, 16'h0004, 4'h0, 4'h0, 4'h0, 10'h000, 1'b1},
        '{10'h029, 16'hffff, 16'h0020, 4'h0, 4'h0, 4'h2, 10'h000, 1'b0},
        '{10'h00a, 16'hffff, 16'h0, 4'h0, 4'h0, 4'h2, 10'h000, 1'b1},
        '{10'h00f, 16'hffff, 16'hffff, 4'hf, 4'hf, 4'hf, 10'h3ff, 1'b0}
    };
    always #5 clock = ~clock;
    som_mapper #(.FLASH_CYCLES(4)) som_mapper_inst (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .in_run(in_run), .in_fault(in_fault),
        .in_bypass_req(in_bypass_req), .in_muted(in_muted),
        .in_override(in_override), .in_group(in_group), .so_phys(so_phys),
        .so_cmd(so_cmd), .so_io_fault(so_io_fault),
        .so_wait_reset(so_wait_reset), .so_cancel_ok(so_cancel_ok),
        .sys(sys), .status_out(status_out), .virt_out(virt_out)
    );
    som_lamp_model som_lamp_model_inst (
        .clock(clock), .rst(rst), .lamp(status_out[0]),
        .count_en(count_en), .toggles(toggles)
    );
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    // Fixed three edges: one for the write or input, one of latency, margin
    task automatic settle();
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd_reg(SOM_ADDR_PHYS_CFG, d);
        `SOM_CHK("cfg0 reset", 32'h0, d)
        rd_reg(SOM_ADDR_CTRL, d);
        `SOM_CHK("ctrl reset", 32'h0, d)
        rd_reg(8'h3c, d);
        `SOM_CHK("unmapped", 32'h0, d)
        // Input held closed since reset, so bypass must be refused
        wr_reg(SOM_ADDR_PHYS_CFG, 32'h048);
        in_bypass_req <= 16'h0010;
        settle();
        `SOM_CHK("bypass pwrup", 1'b0, status_out[0])
        @(posedge clock);
        in_run <= 16'hffef;
        @(posedge clock);
        in_run <= 16'hffff;
        settle();
        `SOM_CHK("bypass seen", 1'b1, status_out[0])
        @(posedge clock);
        in_bypass_req <= 16'h0;
        foreach (rows[i]) begin
            wr_reg(SOM_ADDR_PHYS_CFG, {22'h0, rows[i].cfg});
            wr_reg(SOM_ADDR_PHYS_CFG + 8'h04, {22'h0, rows[i].cfg | 10'h100});
            wr_reg(SOM_ADDR_VIRT_CFG + 8'd124, {22'h0, rows[i].cfg});
            in_run <= rows[i].run;
            in_fault <= rows[i].flt;
            so_phys <= rows[i].sop;
            so_cmd <= rows[i].cmd;
            so_wait_reset <= {4{rows[i].misc[0]}};
            so_cancel_ok <= {4{rows[i].misc[1]}};
            so_io_fault <= {4{rows[i].misc[2]}};
            in_muted <= {16{rows[i].misc[3]}};
            sys <= rows[i].sysv;
            settle();
            `SOM_CHK("conv one", rows[i].e, status_out[0])
            `SOM_CHK("conv two", ~rows[i].e, status_out[1])
            `SOM_CHK("virtual", rows[i].e, virt_out[31])
            rd_reg(SOM_ADDR_PHYS_OUT, d);
            `SOM_CHK("read outs", {~rows[i].e, rows[i].e}, d[1:0])
        end
        @(posedge clock);
        in_run <= 16'hffff;
        in_fault <= 16'h0;
        so_io_fault <= 4'h0;
        in_muted <= 16'h0;
        sys <= '0;
        in_group <= 16'h0006;
        wr_reg(SOM_ADDR_PHYS_CFG, 32'h017);
        wr_reg(SOM_ADDR_PHYS_CFG + 8'h04, 32'h027);
        in_run <= 16'hfffb;
        @(posedge clock);
        in_run <= 16'hfff9;
        settle();
        `SOM_CHK("group first", 2'b10, status_out[1:0])
        @(posedge clock);
        in_run <= 16'hffff;
        settle();
        `SOM_CHK("group held", 2'b10, status_out[1:0])
        @(posedge clock);
        sys <= 10'h001;
        @(posedge clock);
        sys <= '0;
        settle();
        `SOM_CHK("group rearm", 2'b00, status_out[1:0])
        wr_reg(SOM_ADDR_CTRL, 32'h1);
        wr_reg(SOM_ADDR_PHYS_CFG, 32'h006);
        rd_reg(SOM_ADDR_PHYS_CFG, d);
        `SOM_CHK("cfg locked", 32'h017, d)
        wr_reg(SOM_ADDR_CTRL, 32'h0);
        wr_reg(SOM_ADDR_PHYS_CFG, 32'h006);
        in_override <= 16'h0001;
        settle();
        @(posedge clock);
        count_en <= 1'b1;
        repeat (40) @(posedge clock);
        @(negedge clock);
        // Half period of four cycles gives ten changes in forty
        `SOM_CHK("flash", 1'b1, toggles >= 8'd9 && toggles <= 8'd11)
        @(posedge clock);
        count_en <= 1'b0;
        in_bypass_req <= 16'h0001;
        settle();
        `SOM_CHK("mute bypass", 1'b1, status_out[0])
        repeat (5) @(posedge clock);
        @(negedge clock);
        `SOM_CHK("mute steady", 1'b1, status_out[0])
        // Mid-run reset must clear the store and the bypass history
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        settle();
        `SOM_CHK("reset outs", 2'b11, status_out[1:0])
        wr_reg(SOM_ADDR_PHYS_CFG, 32'h008);
        settle();
        `SOM_CHK("bypass reset", 1'b0, status_out[0])
        conclude();
    end
endmodule

// ===== sompkg.sv
// Package for the status output function mapper.
// Assumes one 100 MHz clock and debounced, tested status inputs.
package som_pkg;
    // ****************************************
    // Function codes
    // ****************************************
    typedef enum logic [3:0] {
        SOM_FN_TRACK_INPUT,
        SOM_FN_TRACK_OUTPUT,
        SOM_FN_SYS_LOCKOUT,
        SOM_FN_IO_FAULT,
        SOM_FN_SYS_WAIT_RESET,
        SOM_FN_OUT_WAIT_RESET,
        SOM_FN_MUTE,
        SOM_FN_INPUT_GROUP,
        SOM_FN_BYPASS,
        SOM_FN_INPUT_FAULT,
        SOM_FN_CANCEL_OK
    } som_func_type;

    localparam int SOM_NUM_IN = 16;
    localparam int SOM_NUM_SO = 4;
    localparam int SOM_NUM_PHYS = 8;
    localparam int SOM_NUM_VIRT = 32;
    localparam int SOM_SRC_W = 4;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] SOM_ADDR_PHYS_OUT = 8'h00;
    localparam logic [7:0] SOM_ADDR_VIRT_OUT = 8'h04;
    localparam logic [7:0] SOM_ADDR_CTRL = 8'h08;
    localparam logic [7:0] SOM_ADDR_PHYS_CFG = 8'h40;
    localparam logic [7:0] SOM_ADDR_VIRT_CFG = 8'h80;
    localparam int SOM_CFG_FN_LSB = 0;
    localparam int SOM_CFG_SRC_LSB = 4;
    localparam int SOM_CFG_POL_BIT = 8;
    localparam int SOM_CFG_LOG_BIT = 9;
    localparam int SOM_CTRL_RUN_BIT = 0;
    localparam logic [9:0] SOM_CFG_RESET = 10'h000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SOM_CLK_HZ = 100_000_000;
    localparam int SOM_FLASH_MS = 250;
    localparam int SOM_FLASH_CYCLES = SOM_CLK_HZ / 1000 * SOM_FLASH_MS;
    localparam int SOM_VIRT_MS = 100;
    localparam int SOM_VIRT_CYCLES = SOM_CLK_HZ / 1000 * SOM_VIRT_MS;

    typedef struct packed {
        som_func_type func;
        logic [SOM_SRC_W-1:0] src;
        logic polarity;
        logic track_logical;
    } som_cfg_type;

    typedef struct packed {
        logic sys_lockout;
        logic run_mode;
        logic all_so_off;
        logic fb_fault;
        logic valve_fault;
        logic so_fault;
        logic lamp_fault;
        logic hand_fault;
        logic manual_pwrup;
        logic sys_reset;
    } som_sys_type;
endpackage
